// File: src/fllcs_pkg.sv
package fllcs_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_LSB = 2;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_GAIN = 10'h198;
  localparam logic [IDX_W-1:0] IDX_MODE = 10'h19A;
  localparam logic [IDX_W-1:0] IDX_LOCK = 10'h19B;
  localparam logic [IDX_W-1:0] IDX_OSC = 10'h19D;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h1A0;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h1A1;
  localparam logic [IDX_W-1:0] IDX_INT_ST = 10'h1A2;
  localparam logic [IDX_W-1:0] IDX_INT_MASK = 10'h1A3;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned PGF_LSB = 12;
  localparam int unsigned PGC_LSB = 8;
  localparam int unsigned FGF_LSB = 4;
  localparam int unsigned FGC_LSB = 0;
  localparam int unsigned MODE_LSB = 14;
  localparam int unsigned THR_LSB = 1;
  localparam int unsigned LDEN_BIT = 0;
  localparam int unsigned OSC_LSB = 0;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_REFEN_BIT = 1;
  localparam int unsigned CTRL_GSEL_LSB = 2;
  localparam int unsigned CTRL_APPLY_BIT = 15;
  localparam int unsigned ST_LOCK_BIT = 0;
  localparam int unsigned ST_REF_BIT = 1;
  localparam int unsigned ST_RAW_BIT = 2;
  localparam int unsigned INT_LOCK_BIT = 0;
  localparam int unsigned INT_REF_BIT = 1;
  localparam int unsigned INT_W = 2;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [15:0] GAIN_RST = 16'h21F0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] MODE_INTEGER = 2'h0;
  localparam logic [1:0] MODE_FRACTIONAL = 2'h3;
  localparam logic [3:0] THR_RST = 4'h8;
  localparam logic LDEN_RST = 1'b1;
  localparam logic [1:0] OSC_RST = 2'h0;
  localparam logic [1:0] OSC_LOW = 2'h0;
  localparam logic [1:0] OSC_HIGH = 2'h3;
  localparam logic REFEN_RST = 1'b1;
  localparam logic LOOP_EN_RST = 1'b0;

  typedef enum logic [1:0] {
    FLLCS_GPIO_OFF,
    FLLCS_GPIO_LOCK,
    FLLCS_GPIO_CLK,
    FLLCS_GPIO_SPARE
  } fllcs_gpio_e;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DEB_TIME_NS = 1000;
  localparam int unsigned DEB_CYCLES =
    (DEB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Byte-lane merge of a 16-bit register write.
  function automatic logic [15:0] fllcs_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0] sel);
    fllcs_merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                   sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : fllcs_merge

endpackage : fllcs_pkg

// File: src/fllcs_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module fllcs_debounce #(
  parameter int unsigned CYCLES = fllcs_pkg::DEB_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Status in
  input wire logic tick_en_i,
  input wire logic raw_i,
  // Debounced out
  output logic stable_o,
  output logic change_o
);

  localparam int unsigned CNT_W = (CYCLES < 2) ? 1 : $clog2(CYCLES);

  if (CYCLES < 2) begin : g_bad_cycles
    $error("fllcs_debounce needs at least two cycles");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic stable_q;
  logic change_q;

  // Counting pauses while no clock runs, so no event can be raised.
  wire differ = raw_i != stable_q;
  wire done = differ && tick_en_i && (cnt_q == CNT_W'(CYCLES - 1));
  assign cnt_d = !differ ? '0 : (done ? '0 : (tick_en_i ? cnt_q + 1'b1 : cnt_q));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      stable_q <= 1'b0;
      change_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      stable_q <= done ? raw_i : stable_q;
      change_q <= done;
    end
  end

  assign stable_o = stable_q;
  assign change_o = change_q;

  deb_frozen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tick_en_i |=> $stable(stable_q))
    else $error("debounced level moved with no clock running");

  change_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    change_q |-> $changed(stable_q) ##1 !change_q)
    else $error("change event not a single pulse on a transition");

endmodule : fllcs_debounce
`default_nettype wire

// File: src/fllcs_irq.sv
`timescale 1ns/1ps
`default_nettype none
module fllcs_irq #(
  parameter int unsigned W = fllcs_pkg::INT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Events
  input wire logic [W-1:0] event_i,
  // Software access
  input wire logic clr_we_i,
  input wire logic [W-1:0] clr_i,
  input wire logic mask_we_i,
  input wire logic [W-1:0] mask_i,
  // State
  output logic [W-1:0] status_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);

  if (W < 1) begin : g_bad_width
    $error("fllcs_irq needs at least one source");
  end

  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic [W-1:0] mask_q;
  logic [W-1:0] mask_d;
  logic irq_q;

  // A new event wins over a write-one-to-clear in the same cycle.
  assign status_d = (status_q & ~(clr_we_i ? clr_i : '0)) | event_i;
  assign mask_d = mask_we_i ? mask_i : mask_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = irq_q;

  irq_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_q == |(status_q & mask_q))
    else $error("interrupt line disagrees with status and mask");

  set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (|event_i) |=> ((status_q & $past(event_i)) == $past(event_i)))
    else $error("event lost against a clear");

endmodule : fllcs_irq
`default_nettype wire

// File: src/fllcs_top.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fllcs_top #(
  parameter int unsigned DEB_CYCLES = fllcs_pkg::DEB_CYCLES
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [fllcs_pkg::ADDR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [fllcs_pkg::DATA_W-1:0] DAT_I,
  output logic [fllcs_pkg::DATA_W-1:0] DAT_O,
  output logic ACK_O,
  // Loop status
  input wire logic LOCK_RAW_I,
  input wire logic REF_PRESENT_RAW_I,
  input wire logic SLOW_CLK_RUN_I,
  input wire logic SYSTEM_CLOCK_RUN_I,
  input wire logic LOOP_CLK_I,
  // Loop configuration; all but the enable wait for an apply
  output logic [3:0] PHASE_GAIN_FINE_O,
  output logic [3:0] PHASE_GAIN_COARSE_O,
  output logic [3:0] FREQ_GAIN_FINE_O,
  output logic [3:0] FREQ_GAIN_COARSE_O,
  output logic [1:0] FRACTIONAL_SELECT_O,
  output logic [1:0] OSC_RANGE_SEL_O,
  output logic LOOP_ENABLE_O,
  // Lock detector configuration
  output logic [3:0] LOCK_THRESHOLD_O,
  output logic LOCK_INDICATE_EN_O,
  output logic REF_PRESENT_EN_O,
  // Pin and interrupt
  output logic GPIO_O,
  output logic IRQ_O
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic ack_q;
  logic [fllcs_pkg::DATA_W-1:0] dat_q;

  wire req = CYC_I && STB_I && !ack_q;
  wire wr = req && WE_I;
  wire [fllcs_pkg::IDX_W-1:0] idx = ADR_I[fllcs_pkg::ADDR_W-1:fllcs_pkg::IDX_LSB];
  wire hit_gain = idx == fllcs_pkg::IDX_GAIN;
  wire hit_mode = idx == fllcs_pkg::IDX_MODE;
  wire hit_lock = idx == fllcs_pkg::IDX_LOCK;
  wire hit_osc = idx == fllcs_pkg::IDX_OSC;
  wire hit_ctrl = idx == fllcs_pkg::IDX_CTRL;
  wire hit_stat = idx == fllcs_pkg::IDX_STAT;
  wire hit_int_st = idx == fllcs_pkg::IDX_INT_ST;
  wire hit_int_mask = idx == fllcs_pkg::IDX_INT_MASK;
  wire [15:0] wdat = DAT_I[15:0];

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [15:0] gain_q;
  logic [15:0] gain_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic [3:0] thr_q;
  logic [3:0] thr_d;
  logic lden_q;
  logic lden_d;
  logic [1:0] osc_q;
  logic [1:0] osc_d;
  logic loop_en_q;
  logic loop_en_d;
  logic refen_q;
  logic refen_d;
  logic [1:0] gsel_q;
  logic [1:0] gsel_d;

  localparam logic [1:0] FLLCS_GPIO_OFF_C = 2'(fllcs_pkg::FLLCS_GPIO_OFF);
  localparam logic [1:0] FLLCS_GPIO_LOCK_C = 2'(fllcs_pkg::FLLCS_GPIO_LOCK);
  localparam logic [1:0] FLLCS_GPIO_CLK_C = 2'(fllcs_pkg::FLLCS_GPIO_CLK);

  // Gain fields are exponents handed to the loop unchanged.
  assign gain_d = (wr && hit_gain) ? fllcs_pkg::fllcs_merge(gain_q, wdat, SEL_I[1:0])
                                   : gain_q;

  // Reserved mode and range codes are refused so the loop never sees them.
  wire [1:0] mode_new = wdat[fllcs_pkg::MODE_LSB+1:fllcs_pkg::MODE_LSB];
  wire mode_ok = (mode_new == fllcs_pkg::MODE_INTEGER) ||
                 (mode_new == fllcs_pkg::MODE_FRACTIONAL);
  assign mode_d = (wr && hit_mode && SEL_I[1] && mode_ok) ? mode_new : mode_q;

  wire lock_wr = wr && hit_lock && SEL_I[0];
  assign thr_d = lock_wr ? wdat[fllcs_pkg::THR_LSB+3:fllcs_pkg::THR_LSB] : thr_q;
  assign lden_d = lock_wr ? wdat[fllcs_pkg::LDEN_BIT] : lden_q;

  wire [1:0] osc_new = wdat[fllcs_pkg::OSC_LSB+1:fllcs_pkg::OSC_LSB];
  wire osc_ok = (osc_new == fllcs_pkg::OSC_LOW) || (osc_new == fllcs_pkg::OSC_HIGH);
  assign osc_d = (wr && hit_osc && SEL_I[0] && osc_ok) ? osc_new : osc_q;

  wire ctrl_wr = wr && hit_ctrl && SEL_I[0];
  assign loop_en_d = ctrl_wr ? wdat[fllcs_pkg::CTRL_EN_BIT] : loop_en_q;
  assign refen_d = ctrl_wr ? wdat[fllcs_pkg::CTRL_REFEN_BIT] : refen_q;
  assign gsel_d = ctrl_wr ? wdat[fllcs_pkg::CTRL_GSEL_LSB+1:fllcs_pkg::CTRL_GSEL_LSB]
                          : gsel_q;

  // The apply strobe is honoured only if the loop was already enabled.
  wire apply = wr && hit_ctrl && SEL_I[1] && wdat[fllcs_pkg::CTRL_APPLY_BIT] &&
               loop_en_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      gain_q <= fllcs_pkg::GAIN_RST;
      mode_q <= fllcs_pkg::MODE_RST;
      thr_q <= fllcs_pkg::THR_RST;
      lden_q <= fllcs_pkg::LDEN_RST;
      osc_q <= fllcs_pkg::OSC_RST;
      loop_en_q <= fllcs_pkg::LOOP_EN_RST;
      refen_q <= fllcs_pkg::REFEN_RST;
      gsel_q <= FLLCS_GPIO_OFF_C;
    end else begin
      gain_q <= gain_d;
      mode_q <= mode_d;
      thr_q <= thr_d;
      lden_q <= lden_d;
      osc_q <= osc_d;
      loop_en_q <= loop_en_d;
      refen_q <= refen_d;
      gsel_q <= gsel_d;
    end
  end

  // ---------------------------------------------------------------
  // Applied configuration seen by the loop
  // ---------------------------------------------------------------
  // The threshold is deliberately absent here: it only steers lock reporting.
  logic [15:0] gain_app_q;
  logic [1:0] mode_app_q;
  logic [1:0] osc_app_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      gain_app_q <= fllcs_pkg::GAIN_RST;
      mode_app_q <= fllcs_pkg::MODE_RST;
      osc_app_q <= fllcs_pkg::OSC_RST;
    end else if (apply) begin
      gain_app_q <= gain_q;
      mode_app_q <= mode_q;
      osc_app_q <= osc_q;
    end
  end

  assign PHASE_GAIN_FINE_O = gain_app_q[fllcs_pkg::PGF_LSB+3:fllcs_pkg::PGF_LSB];
  assign PHASE_GAIN_COARSE_O = gain_app_q[fllcs_pkg::PGC_LSB+3:fllcs_pkg::PGC_LSB];
  assign FREQ_GAIN_FINE_O = gain_app_q[fllcs_pkg::FGF_LSB+3:fllcs_pkg::FGF_LSB];
  assign FREQ_GAIN_COARSE_O = gain_app_q[fllcs_pkg::FGC_LSB+3:fllcs_pkg::FGC_LSB];
  assign FRACTIONAL_SELECT_O = mode_app_q;
  assign OSC_RANGE_SEL_O = osc_app_q;
  assign LOOP_ENABLE_O = loop_en_q;
  assign LOCK_THRESHOLD_O = thr_q;
  assign LOCK_INDICATE_EN_O = lden_q;
  assign REF_PRESENT_EN_O = refen_q;

  // ---------------------------------------------------------------
  // Status, debounce and events
  // ---------------------------------------------------------------
  wire lock_gated = LOCK_RAW_I && lden_q;
  wire ref_gated = REF_PRESENT_RAW_I && refen_q;
  wire clk_running = SLOW_CLK_RUN_I || SYSTEM_CLOCK_RUN_I;
  logic lock_stable;
  logic lock_change;
  logic ref_stable;
  logic ref_change;

  fllcs_debounce #(.CYCLES(DEB_CYCLES)) u_lock_deb (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .tick_en_i(clk_running),
    .raw_i(lock_gated),
    .stable_o(lock_stable),
    .change_o(lock_change)
  );

  fllcs_debounce #(.CYCLES(DEB_CYCLES)) u_ref_deb (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .tick_en_i(clk_running),
    .raw_i(ref_gated),
    .stable_o(ref_stable),
    .change_o(ref_change)
  );

  wire ref_stop = ref_change && !ref_stable;
  wire [fllcs_pkg::INT_W-1:0] events = {ref_stop, lock_change};
  wire [fllcs_pkg::INT_W-1:0] int_st;
  wire [fllcs_pkg::INT_W-1:0] int_mask;
  logic irq;

  fllcs_irq #(.W(fllcs_pkg::INT_W)) u_irq (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .event_i(events),
    .clr_we_i(wr && hit_int_st && SEL_I[0]),
    .clr_i(wdat[fllcs_pkg::INT_W-1:0]),
    .mask_we_i(wr && hit_int_mask && SEL_I[0]),
    .mask_i(wdat[fllcs_pkg::INT_W-1:0]),
    .status_o(int_st),
    .mask_o(int_mask),
    .irq_o(irq)
  );
  assign IRQ_O = irq;

  // ---------------------------------------------------------------
  // Pin output
  // ---------------------------------------------------------------
  // One register only, so the raw lock reaches the pin without debounce.
  // The spare select code keeps the pin low, like the off code.
  logic gpio_q;
  wire gpio_d = (gsel_q == FLLCS_GPIO_LOCK_C) ? lock_gated :
                (gsel_q == FLLCS_GPIO_CLK_C) ? LOOP_CLK_I : 1'b0;

  // ---------------------------------------------------------------
  // Read data and acknowledge
  // ---------------------------------------------------------------
  wire [15:0] ctrl_rd = 16'(loop_en_q) | (16'(refen_q) << fllcs_pkg::CTRL_REFEN_BIT) |
                        (16'(gsel_q) << fllcs_pkg::CTRL_GSEL_LSB);
  wire [15:0] stat_rd = (16'(lock_stable) << fllcs_pkg::ST_LOCK_BIT) |
                        (16'(ref_stable) << fllcs_pkg::ST_REF_BIT) |
                        (16'(lock_gated) << fllcs_pkg::ST_RAW_BIT);
  wire [15:0] rd16 =
    hit_gain ? gain_q :
    hit_mode ? (16'(mode_q) << fllcs_pkg::MODE_LSB) :
    hit_lock ? ((16'(thr_q) << fllcs_pkg::THR_LSB) | 16'(lden_q)) :
    hit_osc ? 16'(osc_q) :
    hit_ctrl ? ctrl_rd :
    hit_stat ? stat_rd :
    hit_int_st ? 16'(int_st) :
    hit_int_mask ? 16'(int_mask) : 16'h0000;
  wire [fllcs_pkg::DATA_W-1:0] rd_data = (req && !WE_I) ? 32'(rd16) : 32'h0000_0000;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
      dat_q <= '0;
      gpio_q <= 1'b0;
    end else begin
      ack_q <= req;
      dat_q <= rd_data;
      gpio_q <= gpio_d;
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;
  assign GPIO_O = gpio_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  ack_single_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (CYC_I && STB_I && !ack_q) |=> ack_q ##1 !ack_q)
    else $error("bus answer not a one-cycle acknowledge");

  mode_legal_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (mode_q == fllcs_pkg::MODE_INTEGER) || (mode_q == fllcs_pkg::MODE_FRACTIONAL))
    else $error("reserved loop mode stored");

  loop_isolated_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !apply |=> $stable({gain_app_q, mode_app_q, osc_app_q}))
    else $error("loop settings moved without an apply");

  apply_copy_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    apply |=> (PHASE_GAIN_FINE_O == $past(gain_q[fllcs_pkg::PGF_LSB+3:fllcs_pkg::PGF_LSB])) &&
              (FRACTIONAL_SELECT_O == $past(mode_q)))
    else $error("apply did not copy the configuration");

  apply_gated_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr && hit_ctrl && !loop_en_q) |=> $stable(gain_app_q))
    else $error("apply took effect with the loop disabled");

  lock_pin_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (gsel_q == FLLCS_GPIO_LOCK_C && !lden_q) |=> !GPIO_O)
    else $error("lock shown on the pin with detection disabled");

  ref_stop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ref_stop |=> int_st[fllcs_pkg::INT_REF_BIT] &&
                 (IRQ_O || !int_mask[fllcs_pkg::INT_REF_BIT]))
    else $error("reference stop raised no interrupt");

  osc_legal_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (osc_q == fllcs_pkg::OSC_LOW) || (osc_q == fllcs_pkg::OSC_HIGH))
    else $error("reserved oscillator range stored");

  thr_direct_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    lock_wr |=> (LOCK_THRESHOLD_O == $past(wdat[fllcs_pkg::THR_LSB+3:fllcs_pkg::THR_LSB])))
    else $error("threshold write not passed straight to the detector");

  lock_event_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    lock_change |=> int_st[fllcs_pkg::INT_LOCK_BIT])
    else $error("lock transition raised no interrupt flag");

  // ---------------------------------------------------------------
  // Pin and status checks
  // ---------------------------------------------------------------
  lock_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!lden_q && !lock_stable) |=> !lock_stable)
    else $error("lock reported while detection disabled");

  ref_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!refen_q && !ref_stable) |=> !ref_stable)
    else $error("reference reported while detection disabled");

  gpio_raw_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (gsel_q == FLLCS_GPIO_LOCK_C) |=> (GPIO_O == $past(lock_gated)))
    else $error("pin does not follow the raw lock");

  gpio_clk_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (gsel_q == FLLCS_GPIO_CLK_C) |=> (GPIO_O == $past(LOOP_CLK_I)))
    else $error("pin does not follow the loop clock");

endmodule : fllcs_top
`default_nettype wire

// File: verification/fllcs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack, gpio, irq, loop_en, lden, refen;
  logic lock_raw = 1'b0, ref_raw = 1'b0, slow_run = 1'b0, sys_run = 1'b0, loop_clk = 1'b0;
  logic [3:0] pgf, pgc, fgf, fgc, thr;
  logic [1:0] frac, osc;
  int num_errors = 0;
  int cmp_count = 0;

  always #2.5 clk = ~clk;

  fllcs_top #(.DEB_CYCLES(4)) fllcs_top_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .LOCK_RAW_I(lock_raw),
    .REF_PRESENT_RAW_I(ref_raw), .SLOW_CLK_RUN_I(slow_run), .SYSTEM_CLOCK_RUN_I(sys_run),
    .LOOP_CLK_I(loop_clk), .PHASE_GAIN_FINE_O(pgf), .PHASE_GAIN_COARSE_O(pgc),
    .FREQ_GAIN_FINE_O(fgf), .FREQ_GAIN_COARSE_O(fgc), .FRACTIONAL_SELECT_O(frac),
    .OSC_RANGE_SEL_O(osc), .LOOP_ENABLE_O(loop_en), .LOCK_THRESHOLD_O(thr),
    .LOCK_INDICATE_EN_O(lden), .REF_PRESENT_EN_O(refen), .GPIO_O(gpio), .IRQ_O(irq));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // The request is held until ack is sampled high at a rising edge.
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h3;
    dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      num_errors++;
      $display("[FAIL] %0t bus answer missing", $time);
      stop_test();
    end
  endtask : bus

  task automatic wait_irq();
    int i;
    for (i = 0; i < 50; i++) begin
      if (irq === 1'b1) break;
      tick(1);
    end
    if (i == 50) begin
      num_errors++;
      $display("[FAIL] %0t interrupt missing", $time);
      stop_test();
    end
  endtask : wait_irq

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    bus(1'b0, fllcs_pkg::IDX_GAIN, 32'h0);
    check(rd, 32'h21F0);
    check({16'h0, pgf, pgc, fgf, fgc}, 32'h21F0);
    bus(1'b0, fllcs_pkg::IDX_MODE, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, fllcs_pkg::IDX_LOCK, 32'h0);
    check(rd, 32'h11);
    check({thr, lden, refen}, 6'b100011);
    bus(1'b0, 10'h010, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    bus(1'b1, fllcs_pkg::IDX_GAIN, 32'h8E7F);
    bus(1'b1, fllcs_pkg::IDX_MODE, 32'h4000);
    bus(1'b0, fllcs_pkg::IDX_MODE, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, fllcs_pkg::IDX_MODE, 32'hC000);
    bus(1'b1, fllcs_pkg::IDX_OSC, 32'h3);
    bus(1'b1, 10'h1A0, 32'h8002);
    tick(1);
    check({pgf, pgc, fgf, fgc, frac}, {16'h21F0, 2'h0});
    bus(1'b1, 10'h1A0, 32'h0003);
    bus(1'b1, 10'h1A0, 32'h8003);
    tick(1);
    check({pgf, pgc, fgf, fgc}, 16'h8E7F);
    check({loop_en, frac, osc}, 5'h1F);
    bus(1'b1, fllcs_pkg::IDX_LOCK, 32'h1F);
    tick(1);
    check({thr, pgf, pgc, fgf, fgc}, 20'hF8E7F);
    bus(1'b1, fllcs_pkg::IDX_LOCK, 32'h01);
    tick(1);
    check({thr, frac, osc}, 8'h0F);
    $display("test config done");
  endtask : t_config

  task automatic t_irq();
    bus(1'b1, fllcs_pkg::IDX_INT_MASK, 32'h3);
    slow_run <= 1'b1;
    lock_raw <= 1'b1;
    wait_irq();
    bus(1'b0, fllcs_pkg::IDX_INT_ST, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, fllcs_pkg::IDX_STAT, 32'h0);
    check(rd, 32'h5);
    bus(1'b1, fllcs_pkg::IDX_INT_ST, 32'h1);
    tick(1);
    check(irq, 1'b0);
    slow_run <= 1'b0;
    lock_raw <= 1'b0;
    tick(20);
    bus(1'b0, fllcs_pkg::IDX_INT_ST, 32'h0);
    check(rd, 32'h0);
    check(irq, 1'b0);
    sys_run <= 1'b1;
    wait_irq();
    bus(1'b0, fllcs_pkg::IDX_INT_ST, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, fllcs_pkg::IDX_INT_ST, 32'h1);
    ref_raw <= 1'b1;
    tick(20);
    bus(1'b0, fllcs_pkg::IDX_INT_ST, 32'h0);
    check(rd, 32'h0);
    ref_raw <= 1'b0;
    wait_irq();
    bus(1'b0, fllcs_pkg::IDX_INT_ST, 32'h0);
    check(rd, 32'h2);
    bus(1'b1, fllcs_pkg::IDX_INT_MASK, 32'h1);
    tick(1);
    check(irq, 1'b0);
    bus(1'b1, fllcs_pkg::IDX_INT_MASK, 32'h3);
    tick(1);
    check(irq, 1'b1);
    bus(1'b1, fllcs_pkg::IDX_INT_ST, 32'h2);
    bus(1'b1, 10'h1A0, 32'h0001);
    ref_raw <= 1'b1;
    tick(20);
    bus(1'b0, fllcs_pkg::IDX_STAT, 32'h0);
    check(rd & 32'h2, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_gpio();
    ref_raw <= 1'b0;
    sys_run <= 1'b0;
    bus(1'b1, 10'h1A0, 32'h0007);
    lock_raw <= 1'b1;
    tick(2);
    check(gpio, 1'b1);
    lock_raw <= 1'b0;
    tick(2);
    check(gpio, 1'b0);
    bus(1'b1, 10'h1A0, 32'h000B);
    loop_clk <= 1'b1;
    tick(2);
    check(gpio, 1'b1);
    loop_clk <= 1'b0;
    tick(2);
    check(gpio, 1'b0);
    bus(1'b1, fllcs_pkg::IDX_LOCK, 32'h10);
    lock_raw <= 1'b1;
    sys_run <= 1'b1;
    tick(20);
    bus(1'b0, fllcs_pkg::IDX_STAT, 32'h0);
    check(rd & 32'h1, 32'h0);
    $display("test gpio done");
  endtask : t_gpio

  function automatic int gcd(input int a, input int b);
    int t;
    while (b != 0) begin
      t = a % b;
      a = b;
      b = t;
    end
    return a;
  endfunction : gcd

  // Software side: derive a fractional setup and load the recommended fields.
  task automatic t_recommend();
    int f_ref, f_out, osc_frequency, fb_div, n_int, g;
    logic [1:0] mode;
    f_ref = 12000000;
    f_out = 49152000;
    fb_div = 1;
    osc_frequency = 6 * f_out;
    mode = (f_out % f_ref != 0) ? fllcs_pkg::MODE_FRACTIONAL : fllcs_pkg::MODE_INTEGER;
    n_int = osc_frequency / (fb_div * f_ref);
    g = gcd(fb_div * f_ref, osc_frequency);
    check(32'(n_int >= 4 && n_int <= 255), 32'h1);
    check(32'((osc_frequency - n_int * fb_div * f_ref) / g), 32'h48);
    check(32'((fb_div * f_ref) / g), 32'h7D);
    bus(1'b1, fllcs_pkg::IDX_GAIN, 32'h21F0);
    bus(1'b1, fllcs_pkg::IDX_MODE, {16'h0, mode, 14'h0});
    bus(1'b1, fllcs_pkg::IDX_OSC, 32'h3);
    bus(1'b1, fllcs_pkg::IDX_CTRL, 32'h8001);
    tick(1);
    check({pgf, pgc, fgf, fgc, frac, osc}, 20'h21F0F);
    $display("test recommend done");
  endtask : t_recommend

  initial begin
    tick(6);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_config();
    t_irq();
    t_gpio();
    t_recommend();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
